// file: src/pac_map.svh
// register offsets, field positions, reset values and amplitude scale for the config bank
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH

`define PAC_OFS_ROLE        8'h0e
`define PAC_OFS_PULL        8'h0f
`define PAC_OFS_AMP_ALT     8'h10
`define PAC_OFS_AMP_DEF     8'h11

`define PAC_RST_ROLE        8'h00
`define PAC_RST_PULL        8'h80
`define PAC_RST_AMP_ALT     8'hb0
`define PAC_RST_AMP_DEF     8'h70
`define PAC_RST_AMP_CODE    4'h7
`define PAC_RST_AMP_MV      10'h320

`define PAC_BIT_ROLE        7
`define PAC_BIT_SDATA_PU    3
`define PAC_BIT_SCLK_PU     1
`define PAC_AMP_MSB         7
`define PAC_AMP_LSB         4

`define PAC_AMP_BASE_MV     10'h271
`define PAC_AMP_STEP_MV     10'h019

`define PAC_UNMAPPED_DATA   8'h00

`endif

// file: src/pac_pkg.sv
// types shared by the pull-up and amplitude configuration bank
package pac_pkg;

    typedef enum logic [0:0] {
        PAC_ROLE_SLEW = 1'b0,
        PAC_ROLE_AMP  = 1'b1
    } pac_role_t;

    typedef logic [3:0] pac_amp_code_t;
    typedef logic [9:0] pac_amp_mv_t;
    typedef logic [7:0] pac_byte_t;

    typedef struct packed {
        pac_byte_t     pull_reg;
        pac_byte_t     alt_reg;
        pac_byte_t     def_reg;
        pac_byte_t     role_reg;
        logic [2:0]    mf_sync;
        logic          mf_level;
        pac_byte_t     rdata;
        logic          rvalid;
        logic          pu_sdata;
        logic          pu_sclk;
        pac_role_t     role;
        logic          alt_active;
        pac_amp_code_t amp_code;
        pac_amp_mv_t   amp_mv;
    } pac_state_t;

endpackage

// file: src/pac_amp_sel.sv
// picks the active amplitude code from the pin role and level and converts it to millivolts
`timescale 1ns/100ps
`include "pac_map.svh"

module pac_amp_sel
    import pac_pkg::*;
(
    input  pac_pkg::pac_role_t     role,
    input  logic                   pin_level,
    input  pac_pkg::pac_amp_code_t alt_code,
    input  pac_pkg::pac_amp_code_t def_code,
    output pac_pkg::pac_amp_code_t code,
    output pac_pkg::pac_amp_mv_t   swing_mv,
    output logic                   use_alt
);

    function automatic pac_amp_mv_t code_to_mv(input pac_amp_code_t c);
        code_to_mv = `PAC_AMP_BASE_MV + 10'(c) * `PAC_AMP_STEP_MV;
    endfunction

    always_comb begin
        // in slew role the pin level says nothing about amplitude
        use_alt  = (role == PAC_ROLE_AMP) && pin_level;
        code     = use_alt ? alt_code : def_code;
        swing_mv = code_to_mv(code);
    end

endmodule

// file: src/pac_regs.sv
// pull-up and output amplitude configuration registers with multifunction pin handling
//
// Summary of operation
// - pull-up register bit 3 enables the data line pull-up and bit 1 the clock line pull-up, both reset to 0.
// - while a line's pull-up enable is set, the device holds that line weakly high whenever nothing else drives it.
// - alternate amplitude field bits 7:4, reset 0xb, sets the amplitude when the pin is in amplitude role and high.
// - in slew-rate role the alternate amplitude field is ignored and writing it does not change the outputs.
// - default amplitude bits 7:4, reset 0x7, set the swing in slew-rate role and in amplitude role with the pin low.
// - each 4-bit code maps linearly to the swing, 625 mV at code 0 plus 25 mV per step up to 1000 mV at code 15.
// - the role select bit at position 7, reset 0, makes the pin slew-rate select at 0 and amplitude select at 1.
`timescale 1ns/100ps
`include "pac_map.svh"

module pac_regs
    import pac_pkg::*;
(
    input  logic                   mclk,
    input  logic                   rst,
    input  logic                   ce,
    input  logic                   reg_wr,
    input  logic                   reg_rd,
    input  logic [7:0]             reg_addr,
    input  pac_pkg::pac_byte_t     reg_wdata,
    output pac_pkg::pac_byte_t     reg_rdata,
    output logic                   reg_rvalid,
    input  logic                   mf_pin,
    output logic                   sdata_pullup_en,
    output logic                   sclk_pullup_en,
    output pac_pkg::pac_role_t     mf_role,
    output logic                   amp_alt_active,
    output pac_pkg::pac_amp_code_t amp_code,
    output pac_pkg::pac_amp_mv_t   amp_mv
);

    pac_state_t    st_reg;
    pac_state_t    st_next;
    pac_amp_code_t sel_code;
    pac_amp_mv_t   sel_mv;
    logic          sel_alt;
    pac_role_t     role_now;
    logic [3:0]    wr_hit;
    pac_byte_t     role_after;
    pac_byte_t     pull_after;
    pac_byte_t     alt_after;
    pac_byte_t     def_after;
    logic          level_after;

    localparam pac_state_t ST_RESET = '{
        pull_reg:   `PAC_RST_PULL,
        alt_reg:    `PAC_RST_AMP_ALT,
        def_reg:    `PAC_RST_AMP_DEF,
        role_reg:   `PAC_RST_ROLE,
        mf_sync:    3'h0,
        mf_level:   1'b0,
        rdata:      8'h00,
        rvalid:     1'b0,
        pu_sdata:   1'b0,
        pu_sclk:    1'b0,
        role:       PAC_ROLE_SLEW,
        alt_active: 1'b0,
        amp_code:   `PAC_RST_AMP_CODE,
        amp_mv:     `PAC_RST_AMP_MV
    };

    // one decode serves both the read mux and the write strobes
    function automatic logic [3:0] addr_hit(input logic [7:0] a);
        addr_hit = {a == `PAC_OFS_AMP_DEF,
                    a == `PAC_OFS_AMP_ALT,
                    a == `PAC_OFS_PULL,
                    a == `PAC_OFS_ROLE};
    endfunction

    function automatic pac_byte_t read_mux(input logic [7:0] a, input pac_state_t s);
        logic [3:0] h;
        h = addr_hit(a);
        case (h)
            4'h1: read_mux = s.role_reg;
            4'h2: read_mux = s.pull_reg;
            4'h4: read_mux = s.alt_reg;
            4'h8: read_mux = s.def_reg;
            default: read_mux = `PAC_UNMAPPED_DATA;
        endcase
    endfunction

    // contents of a register after this edge: the written byte if it is addressed, else what it held
    function automatic pac_byte_t next_byte(input logic      wr,
                                            input logic      sel,
                                            input pac_byte_t wdata,
                                            input pac_byte_t held);
        next_byte = (wr && sel) ? wdata : held;
    endfunction

    // pin filter: a change is taken only once the second and third stages agree
    function automatic logic filt_level(input logic [2:0] sync, input logic held);
        filt_level = (sync[1] == sync[2]) ? sync[2] : held;
    endfunction

    // the write path is resolved outside the state copy, so selection sees the new fields
    // without a loop through the state struct; outputs change on the same edge that stores the write
    always_comb begin
        wr_hit      = addr_hit(reg_addr);
        role_after  = next_byte(reg_wr, wr_hit[0], reg_wdata, st_reg.role_reg);
        pull_after  = next_byte(reg_wr, wr_hit[1], reg_wdata, st_reg.pull_reg);
        alt_after   = next_byte(reg_wr, wr_hit[2], reg_wdata, st_reg.alt_reg);
        def_after   = next_byte(reg_wr, wr_hit[3], reg_wdata, st_reg.def_reg);
        level_after = filt_level(st_reg.mf_sync, st_reg.mf_level);
        role_now    = pac_role_t'(role_after[`PAC_BIT_ROLE]);
    end

    pac_amp_sel u_amp_sel (
        .role      (role_now),
        .pin_level (level_after),
        .alt_code  (alt_after[`PAC_AMP_MSB:`PAC_AMP_LSB]),
        .def_code  (def_after[`PAC_AMP_MSB:`PAC_AMP_LSB]),
        .code      (sel_code),
        .swing_mv  (sel_mv),
        .use_alt   (sel_alt)
    );

    always_comb begin
        st_next = st_reg;

        st_next.mf_sync  = {st_reg.mf_sync[1:0], mf_pin};
        st_next.mf_level = level_after;

        // reserved bits are kept as written so software reads back what it stored
        st_next.role_reg = role_after;
        st_next.pull_reg = pull_after;
        st_next.alt_reg  = alt_after;
        st_next.def_reg  = def_after;

        // a read in the same cycle as a write returns the old contents
        st_next.rvalid = reg_rd;
        if (reg_rd) begin
            st_next.rdata = read_mux(reg_addr, st_reg);
        end

        // the pull-up is only a weak keeper; the host controller keeps these clear on a live bus
        st_next.pu_sdata = pull_after[`PAC_BIT_SDATA_PU];
        st_next.pu_sclk  = pull_after[`PAC_BIT_SCLK_PU];

        st_next.role       = role_now;
        st_next.alt_active = sel_alt;
        st_next.amp_code   = sel_code;
        st_next.amp_mv     = sel_mv;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= ST_RESET;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata       = st_reg.rdata;
    assign reg_rvalid      = st_reg.rvalid;
    assign sdata_pullup_en = st_reg.pu_sdata;
    assign sclk_pullup_en  = st_reg.pu_sclk;
    assign mf_role         = st_reg.role;
    assign amp_alt_active  = st_reg.alt_active;
    assign amp_code        = st_reg.amp_code;
    assign amp_mv          = st_reg.amp_mv;

endmodule

// file: testbench/pac_chk.sv
// port assertions for the pull-up and amplitude config bank
`timescale 1ns/100ps
module pac_chk
    import pac_pkg::*;
(
    input logic                   mclk,
    input logic                   rst,
    input logic                   ce,
    input logic                   reg_wr,
    input logic [7:0]             reg_addr,
    input pac_pkg::pac_byte_t     reg_wdata,
    input logic                   mf_pin,
    input logic                   sdata_pullup_en,
    input logic                   sclk_pullup_en,
    input pac_pkg::pac_role_t     mf_role,
    input logic                   amp_alt_active,
    input pac_pkg::pac_amp_code_t amp_code,
    input pac_pkg::pac_amp_mv_t   amp_mv
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence wr_at(logic [7:0] a); ce && reg_wr && reg_addr == a; endsequence
    // six steady cycles outlast the three-stage pin filter
    sequence pin_at(logic lv); (ce && mf_role == PAC_ROLE_AMP && mf_pin == lv)[*6]; endsequence
    pull_bits_a: assert property (wr_at(8'h0f) |=>
        {sdata_pullup_en, sclk_pullup_en} == {$past(reg_wdata[3]), $past(reg_wdata[1])}) else $error("pull-up bits");
    role_bit_a: assert property (wr_at(8'h0e) |=> mf_role == $past(reg_wdata[7])) else $error("role bit");
    swing_map_a: assert property (amp_mv == 10'h271 + 10'h019 * amp_code) else $error("swing map");
    slew_def_a: assert property (mf_role == PAC_ROLE_SLEW |-> !amp_alt_active) else $error("alt in slew");
    alt_ignored_a: assert property (wr_at(8'h10) ##0 mf_role == PAC_ROLE_SLEW |=> $stable(amp_code))
        else $error("alt write moved code");
    pin_high_a: assert property (pin_at(1'b1) |-> amp_alt_active) else $error("pin high");
    pin_low_a: assert property (pin_at(1'b0) |-> !amp_alt_active) else $error("pin low");
endmodule

bind pac_regs pac_chk chk (.mclk(mclk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .mf_pin(mf_pin), .sdata_pullup_en(sdata_pullup_en), .sclk_pullup_en(sclk_pullup_en),
    .mf_role(mf_role), .amp_alt_active(amp_alt_active), .amp_code(amp_code), .amp_mv(amp_mv));

// file: testbench/pac_host.sv
// host model driving the register strobes at falling edges
`timescale 1ns/100ps
module pac_host (
    input  logic       mclk,
    output logic       ce,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input  logic [7:0] reg_rdata,
    input  logic       reg_rvalid
);
    initial begin
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // enable changes at a falling edge so the next rising edge sees it settled
    task automatic set_ce(input logic en);
        @(negedge mclk);
        ce = en;
    endtask
    // one write per call; the strobe drops at the next falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = dat;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    // answer is registered, so it is settled by the next falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic v);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        dat = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the pull-up and amplitude config bank
`timescale 1ns/100ps
module tb;
    import pac_pkg::*;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic          mf_pin = 1'b0;
    logic          ce, reg_wr, reg_rd, reg_rvalid, sdata_pullup_en, sclk_pullup_en, amp_alt_active, v;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata, d;
    pac_role_t     mf_role;
    pac_amp_code_t amp_code;
    pac_amp_mv_t   amp_mv;
    int            miscompares = 0;
    int            n_checks = 0;
    logic [7:0]    rst_val [4] = '{8'h00, 8'h80, 8'hb0, 8'h70};
    always #2.5 mclk = ~mclk;
    pac_regs uut (.mclk(mclk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mf_pin(mf_pin),
        .sdata_pullup_en(sdata_pullup_en), .sclk_pullup_en(sclk_pullup_en), .mf_role(mf_role),
        .amp_alt_active(amp_alt_active), .amp_code(amp_code), .amp_mv(amp_mv));
    pac_host host (.mclk(mclk), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d, v);
        check("rvalid", {9'h000, v}, 10'h001);
        check("rdata", {2'h0, d}, {2'h0, exp});
        @(negedge mclk);
        check("rvalid drop", {9'h000, reg_rvalid}, 10'h000);
    endtask
    task automatic amp(input logic alt, input logic [3:0] c);
        check("alt", {9'h000, amp_alt_active}, {9'h000, alt});
        check("code", {6'h00, amp_code}, {6'h00, c});
        check("mv", amp_mv, 10'h271 + 10'h019 * c);
    endtask
    // far above the roughly one hundred cycles the sequence needs
    initial begin
        #20000;
        miscompares++;
        results();
    end
    initial begin
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) rdchk(8'h0e + i[7:0], rst_val[i]);
        amp(1'b0, 4'h7);
        host.wr(8'h20, 8'hff);
        rdchk(8'h20, 8'h00);
        $display("reset values done");
        host.wr(8'h0f, 8'h08);
        check("sdata pu", {8'h00, sdata_pullup_en, sclk_pullup_en}, 10'h002);
        host.wr(8'h0f, 8'h02);
        check("pu pair", {8'h00, sdata_pullup_en, sclk_pullup_en}, 10'h001);
        rdchk(8'h0f, 8'h02);
        host.wr(8'h0f, 8'h80);
        check("pu clear", {8'h00, sdata_pullup_en, sclk_pullup_en}, 10'h000);
        $display("pull-up test done");
        host.wr(8'h10, 8'hf0);
        mf_pin = 1'b1;
        repeat (8) @(negedge mclk);
        amp(1'b0, 4'h7);
        rdchk(8'h10, 8'hf0);
        for (int c = 0; c < 16; c++) begin
            host.wr(8'h11, {c[3:0], 4'h0});
            amp(1'b0, c[3:0]);
        end
        host.set_ce(1'b0);
        host.wr(8'h11, 8'h50);
        amp(1'b0, 4'hf);
        host.set_ce(1'b1);
        rdchk(8'h11, 8'hf0);
        $display("slew role test done");
        host.wr(8'h11, 8'h30);
        host.wr(8'h0e, 8'h80);
        check("role", {9'h000, mf_role}, 10'h001);
        repeat (8) @(negedge mclk);
        amp(1'b1, 4'hf);
        mf_pin = 1'b0;
        repeat (8) @(negedge mclk);
        amp(1'b0, 4'h3);
        $display("amplitude role test done");
        results();
    end
endmodule
